/* File: hdl/rrte_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the executor.
// Assumes: Included by bare name wherever these macros are needed.
// Notes: Definitions only.
`ifndef RRTE_CFG_SVH
`define RRTE_CFG_SVH

// ====================================================================
// Register offsets (byte addresses)
`define RRTE_OFS_INSTR 12'h000
`define RRTE_OFS_STAT 12'h004
`define RRTE_OFS_WREG 12'h008
`define RRTE_OFS_FLAGS 12'h00c
`define RRTE_OFS_BANK 12'h010
`define RRTE_OFS_SHADOW 12'h014
`define RRTE_OFS_STACK_TOP 12'h018
`define RRTE_OFS_PC 12'h01c
`define RRTE_OFS_LATCH 12'h020
`define RRTE_OFS_BYTE_PTR 12'h024
`define RRTE_OFS_TBLLAT 12'h028
`define RRTE_OFS_FILE 12'h080
`define RRTE_FILE_HI 12'h0fc

// ====================================================================
// Field positions
`define RRTE_INSTR_TWO_WORD 16
`define RRTE_FLAG_C 0
`define RRTE_FLAG_Z 2
`define RRTE_FLAG_N 4
`define RRTE_STAT_BUSY 0
`define RRTE_STAT_SKIP 1

// ====================================================================
// Opcode patterns
`define RRTE_OP_SKIP 4'ha
`define RRTE_OP_RET 15'h0009
`define RRTE_OP_ROTATE 6'h0d
`define RRTE_OP_TBL_READ 14'h0002

// ====================================================================
// Reset values and timing
`define RRTE_RST_BYTE 8'h00
`define RRTE_RST_PTR 21'h000000
`define RRTE_PHASE_DIV 3'h2
`define RRTE_PHASE_LAST 2'h3

`endif

/* File: hdl/rrte_pkg.sv */
// Purpose: Types shared by the executor modules.
// Assumes: Constants live in rrte_cfg.svh.
// Notes: None.
package rrte_pkg;
	// ====================================================================
	// Execution sequencer state
	typedef enum logic [0:0] {
		RRTE_IDLE = 1'b0,
		RRTE_RUN = 1'b1
	} rrte_state_e;

	// ====================================================================
	// Instruction classes
	typedef enum logic [2:0] {
		RRTE_CLS_NO_OPERATION = 3'h0,
		RRTE_CLS_SKIP = 3'h1,
		RRTE_CLS_RET = 3'h2,
		RRTE_CLS_ROTATE = 3'h3,
		RRTE_CLS_TBL_READ = 3'h4
	} rrte_cls_e;

	// ====================================================================
	// Table pointer modes
	typedef enum logic [1:0] {
		RRTE_PTR_KEEP = 2'h0,
		RRTE_PTR_POSTINC = 2'h1,
		RRTE_PTR_POSTDEC = 2'h2,
		RRTE_PTR_PREINC = 2'h3
	} rrte_ptr_e;
endpackage

/* File: hdl/rrte_tbl_if.sv */
// Purpose: Link between the sequencer and the table read unit.
// Assumes: Phase strobes are one pclk wide.
// Notes: None.
`timescale 1ns/1ps
interface rrte_tbl_if;
	logic q1;                    // Phase 1 strobe of table read second cycle
	logic q2;                    // Phase 2 strobe of table read second cycle
	logic q4;                    // Phase 4 strobe of table read second cycle
	rrte_pkg::rrte_ptr_e mode;   // Pointer update mode
	logic ptr_wr;                // Software write of the pointer
	logic [20:0] ptr_wdata;      // Pointer write data
	logic [20:0] ptr;            // Current pointer
	logic [7:0] latch;           // Table latch contents
	modport exec (output q1, q2, q4, mode, ptr_wr, ptr_wdata, input ptr, latch);
	modport unit (input q1, q2, q4, mode, ptr_wr, ptr_wdata, output ptr, latch);
endinterface

/* File: hdl/rrte_table_unit.sv */
// Purpose: Table byte pointer, program memory access and table latch.
// Assumes: Program memory returns a word one pclk after its read strobe.
// Notes: Phases are at least two pclk apart, so data is held before phase 4.
`timescale 1ns/1ps
`include "rrte_cfg.svh"
module rrte_table_unit (
	input wire logic pclk,          // Clock
	input wire logic presetn,       // Asynchronous reset, active low
	rrte_tbl_if.unit tbl,           // Sequencer side
	output logic [19:0] pm_addr,    // Program memory word address
	output logic pm_rd,             // Program memory read strobe
	input wire logic [15:0] pm_rdata // Program memory word
);
	logic [20:0] ptr_q, ptr_d;
	logic [7:0] latch_q, latch_d;
	logic [15:0] word_q, word_d;
	logic [19:0] addr_q, addr_d;
	logic rd_q, rd_d;

	// ====================================================================
	// Next pointer, access and latch values
	always_comb begin
		ptr_d = ptr_q;
		latch_d = latch_q;
		word_d = word_q;
		addr_d = addr_q;
		rd_d = 1'b0;
		if (tbl.ptr_wr) begin
			ptr_d = tbl.ptr_wdata;
		end
		if (tbl.q1 && tbl.mode == rrte_pkg::RRTE_PTR_PREINC) begin
			ptr_d = ptr_q + 21'h000001;
		end
		if (tbl.q2) begin
			addr_d = ptr_q[20:1]; // Word holding the addressed byte
			rd_d = 1'b1;
		end
		if (rd_q) begin
			word_d = pm_rdata;
		end
		if (tbl.q4) begin
			latch_d = ptr_q[0] ? word_q[15:8] : word_q[7:0];
			unique case (tbl.mode)
				rrte_pkg::RRTE_PTR_POSTINC: ptr_d = ptr_q + 21'h000001;
				rrte_pkg::RRTE_PTR_POSTDEC: ptr_d = ptr_q - 21'h000001;
				rrte_pkg::RRTE_PTR_KEEP, rrte_pkg::RRTE_PTR_PREINC: ptr_d = ptr_q;
			endcase
		end
	end

	// ====================================================================
	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_q <= `RRTE_RST_PTR;
			latch_q <= `RRTE_RST_BYTE;
			word_q <= 16'h0000;
			addr_q <= 20'h00000;
			rd_q <= 1'b0;
		end else begin
			ptr_q <= ptr_d;
			latch_q <= latch_d;
			word_q <= word_d;
			addr_q <= addr_d;
			rd_q <= rd_d;
		end
	end

	assign tbl.ptr = ptr_q;
	assign tbl.latch = latch_q;
	assign pm_addr = addr_q;
	assign pm_rd = rd_q;
endmodule

/* File: hdl/rrte_core.sv */
// Purpose: Executes bit-test skip, return, rotate-through-carry and table read.
// Assumes: APB slave; program memory answers one pclk after pm_rd.
// Notes: An instruction cycle is four phases of PHASE_DIV pclk each.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "rrte_cfg.svh"
module rrte_core (
	input wire logic pclk,           // Clock, 100 MHz
	input wire logic presetn,        // Asynchronous reset, active low
	input wire logic psel,           // APB select
	input wire logic penable,        // APB enable
	input wire logic pwrite,         // APB write
	input wire logic [11:0] paddr,   // APB byte address
	input wire logic [31:0] pwdata,  // APB write data
	output logic [31:0] prdata,      // APB read data
	output logic pready,             // APB ready
	output logic pslverr,            // APB error on unmapped address
	output logic [19:0] pm_addr,     // Program memory word address
	output logic pm_rd,              // Program memory read strobe
	input wire logic [15:0] pm_rdata // Program memory word
);
	rrte_tbl_if tbl ();

	rrte_pkg::rrte_state_e state_q, state_d;
	rrte_pkg::rrte_cls_e cls_q, cls_d;
	logic [15:0] op_q, op_d;
	logic two_word_q, two_word_d;
	logic [2:0] div_q, div_d;
	logic [1:0] ph_q, ph_d;
	logic [1:0] cyc_q, cyc_d;
	logic [1:0] ncyc_q, ncyc_d;
	logic skip_q, skip_d;
	logic [7:0] w_q, w_d;
	logic [7:0] flags_q, flags_d;
	logic [7:0] bank_q, bank_d;
	logic [7:0] w_sh_q, w_sh_d;
	logic [7:0] flags_sh_q, flags_sh_d;
	logic [7:0] bank_sh_q, bank_sh_d;
	logic [20:0] stack_top_q, stack_top_d;
	logic [20:0] pc_q, pc_d;
	logic [7:0] pcu_q, pcu_d;
	logic [7:0] pch_q, pch_d;
	logic [7:0] opnd_q, opnd_d;
	logic [7:0] res_q, res_d;
	logic res_c_q, res_c_d;
	logic [7:0] file_q [32];
	logic [7:0] file_d [32];
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;

	logic tick;
	logic [4:0] fidx;
	logic apb_wr;
	logic apb_rd;
	logic busy;
	logic file_hit;
	logic [4:0] apb_idx;
	logic mapped;
	logic [31:0] rd_val;
	rrte_pkg::rrte_cls_e new_cls;

	// ====================================================================
	// Decode helpers
	assign tick = (state_q == rrte_pkg::RRTE_RUN) && (div_q == `RRTE_PHASE_DIV - 3'h1);
	assign busy = (state_q == rrte_pkg::RRTE_RUN);
	// Access bank is the low half, else the half picked by bank_select_reg
	assign fidx = op_q[8] ? {bank_q[0], op_q[3:0]} : {1'b0, op_q[3:0]};
	assign apb_wr = psel && penable && pready_q && pwrite && !pslverr_q;
	assign apb_rd = psel && penable && !pready_q;
	assign file_hit = paddr >= `RRTE_OFS_FILE && paddr <= `RRTE_FILE_HI && paddr[1:0] == 2'h0;
	assign apb_idx = paddr[6:2];

	// Class of a newly written opcode
	always_comb begin
		if (pwdata[15:12] == `RRTE_OP_SKIP) begin
			new_cls = rrte_pkg::RRTE_CLS_SKIP;
		end else if (pwdata[15:1] == `RRTE_OP_RET) begin
			new_cls = rrte_pkg::RRTE_CLS_RET;
		end else if (pwdata[15:10] == `RRTE_OP_ROTATE) begin
			new_cls = rrte_pkg::RRTE_CLS_ROTATE;
		end else if (pwdata[15:2] == `RRTE_OP_TBL_READ) begin
			new_cls = rrte_pkg::RRTE_CLS_TBL_READ;
		end else begin
			new_cls = rrte_pkg::RRTE_CLS_NO_OPERATION;
		end
	end

	// ====================================================================
	// Table unit strobes, all in the second instruction cycle
	assign tbl.q1 = tick && cls_q == rrte_pkg::RRTE_CLS_TBL_READ && cyc_q == 2'h1 && ph_q == 2'h0;
	assign tbl.q2 = tick && cls_q == rrte_pkg::RRTE_CLS_TBL_READ && cyc_q == 2'h1 && ph_q == 2'h1;
	assign tbl.q4 = tick && cls_q == rrte_pkg::RRTE_CLS_TBL_READ && cyc_q == 2'h1 && ph_q == 2'h3;
	assign tbl.mode = rrte_pkg::rrte_ptr_e'(op_q[1:0]);
	assign tbl.ptr_wr = apb_wr && !busy && paddr == `RRTE_OFS_BYTE_PTR;
	assign tbl.ptr_wdata = pwdata[20:0];

	rrte_table_unit u_table (
		.pclk(pclk),
		.presetn(presetn),
		.tbl(tbl),
		.pm_addr(pm_addr),
		.pm_rd(pm_rd),
		.pm_rdata(pm_rdata)
	);

	// ====================================================================
	// Read data selection
	always_comb begin
		mapped = 1'b1;
		rd_val = 32'h00000000;
		if (file_hit) begin
			rd_val = {24'h000000, file_q[apb_idx]};
		end else begin
			unique case (paddr)
				`RRTE_OFS_INSTR: rd_val = {15'h0000, two_word_q, op_q};
				`RRTE_OFS_STAT: rd_val = {26'h0000000, ncyc_q, 2'h0, skip_q, busy};
				`RRTE_OFS_WREG: rd_val = {24'h000000, w_q};
				`RRTE_OFS_FLAGS: rd_val = {24'h000000, flags_q};
				`RRTE_OFS_BANK: rd_val = {24'h000000, bank_q};
				`RRTE_OFS_SHADOW: rd_val = {8'h00, bank_sh_q, flags_sh_q, w_sh_q};
				`RRTE_OFS_STACK_TOP: rd_val = {11'h000, stack_top_q};
				`RRTE_OFS_PC: rd_val = {11'h000, pc_q};
				`RRTE_OFS_LATCH: rd_val = {16'h0000, pcu_q, pch_q};
				`RRTE_OFS_BYTE_PTR: rd_val = {11'h000, tbl.ptr};
				`RRTE_OFS_TBLLAT: rd_val = {24'h000000, tbl.latch};
				default: mapped = 1'b0;
			endcase
		end
	end

	// ====================================================================
	// APB answer: one wait state, then ready with data or error
	always_comb begin
		pready_d = apb_rd;
		pslverr_d = apb_rd && !mapped;
		prdata_d = apb_rd ? rd_val : prdata_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// ====================================================================
	// Sequencer, core registers and file registers
	always_comb begin
		state_d = state_q;
		cls_d = cls_q;
		op_d = op_q;
		two_word_d = two_word_q;
		div_d = div_q;
		ph_d = ph_q;
		cyc_d = cyc_q;
		ncyc_d = ncyc_q;
		skip_d = skip_q;
		w_d = w_q;
		flags_d = flags_q;
		bank_d = bank_q;
		w_sh_d = w_sh_q;
		flags_sh_d = flags_sh_q;
		bank_sh_d = bank_sh_q;
		stack_top_d = stack_top_q;
		pc_d = pc_q;
		pcu_d = pcu_q;
		pch_d = pch_q;
		opnd_d = opnd_q;
		res_d = res_q;
		res_c_d = res_c_q;
		file_d = file_q;
		// Software writes, only while no instruction runs
		if (apb_wr && !busy) begin
			if (file_hit) begin
				file_d[apb_idx] = pwdata[7:0];
			end
			unique case (paddr)
				`RRTE_OFS_INSTR: begin
					op_d = pwdata[15:0];
					two_word_d = pwdata[`RRTE_INSTR_TWO_WORD];
					cls_d = new_cls;
					state_d = rrte_pkg::RRTE_RUN;
					div_d = 3'h0;
					ph_d = 2'h0;
					cyc_d = 2'h0;
					skip_d = 1'b0;
					// Two cycles for return and table read, one otherwise
					ncyc_d = (new_cls == rrte_pkg::RRTE_CLS_RET ||
						new_cls == rrte_pkg::RRTE_CLS_TBL_READ) ? 2'h2 : 2'h1;
				end
				`RRTE_OFS_WREG: w_d = pwdata[7:0];
				`RRTE_OFS_FLAGS: flags_d = pwdata[7:0];
				`RRTE_OFS_BANK: bank_d = pwdata[7:0];
				`RRTE_OFS_SHADOW: begin
					w_sh_d = pwdata[7:0];
					flags_sh_d = pwdata[15:8];
					bank_sh_d = pwdata[23:16];
				end
				`RRTE_OFS_STACK_TOP: stack_top_d = pwdata[20:0];
				`RRTE_OFS_LATCH: begin
					pch_d = pwdata[7:0];
					pcu_d = pwdata[15:8];
				end
				default: begin
				end
			endcase
		end
		// Phase divider and cycle counting
		if (busy) begin
			div_d = tick ? 3'h0 : div_q + 3'h1;
		end
		if (tick) begin
			ph_d = ph_q + 2'h1;
			if (ph_q == `RRTE_PHASE_LAST) begin
				if (cyc_q == ncyc_q - 2'h1) begin
					state_d = rrte_pkg::RRTE_IDLE;
				end else begin
					cyc_d = cyc_q + 2'h1;
				end
			end
			// Phase 2 reads the operand, phase 3 processes, phase 4 writes
			if (cyc_q == 2'h0) begin
				unique case (cls_q)
					rrte_pkg::RRTE_CLS_SKIP: begin
						if (ph_q == 2'h1) begin
							opnd_d = file_q[fidx];
						end
						if (ph_q == 2'h2 && opnd_q[op_q[11:9]]) begin
							skip_d = 1'b1; // Fetched word becomes no_operation
							ncyc_d = two_word_q ? 2'h3 : 2'h2;
						end
					end
					rrte_pkg::RRTE_CLS_ROTATE: begin
						if (ph_q == 2'h1) begin
							opnd_d = file_q[fidx];
						end
						if (ph_q == 2'h2) begin
							res_d = {opnd_q[6:0], flags_q[`RRTE_FLAG_C]};
							res_c_d = opnd_q[7];
						end
						if (ph_q == 2'h3) begin
							if (op_q[9]) begin
								file_d[fidx] = res_q;
							end else begin
								w_d = res_q;
							end
							flags_d[`RRTE_FLAG_C] = res_c_q;
							flags_d[`RRTE_FLAG_N] = res_q[7];
							flags_d[`RRTE_FLAG_Z] = (res_q == 8'h00);
						end
					end
					rrte_pkg::RRTE_CLS_RET: begin
						// Pop in the last phase of the first cycle; latches untouched
						if (ph_q == 2'h3) begin
							pc_d = stack_top_q;
							if (op_q[0]) begin
								w_d = w_sh_q;
								flags_d = flags_sh_q;
								bank_d = bank_sh_q;
							end
						end
					end
					rrte_pkg::RRTE_CLS_NO_OPERATION, rrte_pkg::RRTE_CLS_TBL_READ: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= rrte_pkg::RRTE_IDLE;
			cls_q <= rrte_pkg::RRTE_CLS_NO_OPERATION;
			op_q <= 16'h0000;
			two_word_q <= 1'b0;
			div_q <= 3'h0;
			ph_q <= 2'h0;
			cyc_q <= 2'h0;
			ncyc_q <= 2'h0;
			skip_q <= 1'b0;
			w_q <= `RRTE_RST_BYTE;
			flags_q <= `RRTE_RST_BYTE;
			bank_q <= `RRTE_RST_BYTE;
			w_sh_q <= `RRTE_RST_BYTE;
			flags_sh_q <= `RRTE_RST_BYTE;
			bank_sh_q <= `RRTE_RST_BYTE;
			stack_top_q <= `RRTE_RST_PTR;
			pc_q <= `RRTE_RST_PTR;
			pcu_q <= `RRTE_RST_BYTE;
			pch_q <= `RRTE_RST_BYTE;
			opnd_q <= `RRTE_RST_BYTE;
			res_q <= `RRTE_RST_BYTE;
			res_c_q <= 1'b0;
			for (int i = 0; i < 32; i++) begin
				file_q[i] <= `RRTE_RST_BYTE;
			end
		end else begin
			state_q <= state_d;
			cls_q <= cls_d;
			op_q <= op_d;
			two_word_q <= two_word_d;
			div_q <= div_d;
			ph_q <= ph_d;
			cyc_q <= cyc_d;
			ncyc_q <= ncyc_d;
			skip_q <= skip_d;
			w_q <= w_d;
			flags_q <= flags_d;
			bank_q <= bank_d;
			w_sh_q <= w_sh_d;
			flags_sh_q <= flags_sh_d;
			bank_sh_q <= bank_sh_d;
			stack_top_q <= stack_top_d;
			pc_q <= pc_d;
			pcu_q <= pcu_d;
			pch_q <= pch_d;
			opnd_q <= opnd_d;
			res_q <= res_d;
			res_c_q <= res_c_d;
			file_q <= file_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule

/* File: verif/rrte_core_sva.sv */
// Purpose: Port-level checker for the executor top.
// Assumes: Single pclk domain, presetn async active low.
// Notes: Bound to rrte_core at the foot of this file.
`timescale 1ns/1ps
`include "rrte_cfg.svh"
module rrte_core_sva (
	input wire logic pclk,           // Clock
	input wire logic presetn,        // Reset, active low
	input wire logic psel,           // APB select
	input wire logic penable,        // APB enable
	input wire logic pwrite,         // APB write
	input wire logic [11:0] paddr,   // APB address
	input wire logic [31:0] pwdata,  // APB write data
	input wire logic [31:0] prdata,  // APB read data
	input wire logic pready,         // APB ready
	input wire logic pslverr,        // APB error
	input wire logic [19:0] pm_addr, // Program memory address
	input wire logic pm_rd,          // Program memory strobe
	input wire logic [15:0] pm_rdata // Program memory word
);
	// ========
	// Decode helpers
	logic unmapped;
	logic wr_instr;
	assign unmapped = (paddr[1:0] != 2'h0) || (paddr > `RRTE_OFS_TBLLAT &&
		paddr < `RRTE_OFS_FILE) || (paddr > `RRTE_FILE_HI);
	assign wr_instr = psel && penable && pready && pwrite && (paddr == `RRTE_OFS_INSTR);

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ========
	// APB answer
	property p_ready_wait; psel && penable && !pready |=> pready; endproperty
	property p_ready_pulse; pready |=> !pready; endproperty
	property p_ready_access; pready |-> psel && penable; endproperty
	property p_err_map; pready |-> (pslverr == unmapped); endproperty
	property p_err_data; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ready late");
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
	a_ready_access: assert property (p_ready_access) else $error("ready outside access");
	a_err_map: assert property (p_err_map) else $error("error flag wrong");
	a_err_data: assert property (p_err_data) else $error("error read data not zero");

	// ========
	// Program memory access
	property p_tbl_fetch;
		wr_instr && pwdata[15:2] == `RRTE_OP_TBL_READ |-> ##[10:14] pm_rd;
	endproperty
	property p_no_fetch;
		wr_instr && pwdata[15:2] != `RRTE_OP_TBL_READ |=> !pm_rd [*8];
	endproperty
	property p_one_fetch; pm_rd |=> !pm_rd [*8]; endproperty
	property p_addr_hold; pm_rd |=> $stable(pm_addr) [*2]; endproperty
	a_tbl_fetch: assert property (p_tbl_fetch) else $error("table fetch mistimed");
	a_no_fetch: assert property (p_no_fetch) else $error("stray fetch");
	a_one_fetch: assert property (p_one_fetch) else $error("double fetch");
	a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved");

	c_fetch: cover property (pm_rd);
	c_err: cover property (pready && pslverr);
	c_instr: cover property (wr_instr);
endmodule

bind rrte_core rrte_core_sva i_rrte_core_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata));

/* File: verif/rrte_pm_model.sv */
// Purpose: Program memory array seen by the table read path.
// Assumes: Word valid the cycle of the strobe and the one after.
// Notes: Outside that window the data lines toggle every cycle.
`timescale 1ns/1ps
module rrte_pm_model (
	input wire logic pclk,           // Clock
	input wire logic presetn,        // Reset, active low
	input wire logic [19:0] pm_addr, // Word address
	input wire logic pm_rd,          // Read strobe
	output logic [15:0] pm_rdata     // Word out
);
	logic rd_late_q;
	logic [15:0] junk_q;
	// Contents depend on every address bit
	function automatic logic [15:0] pm_word(input logic [19:0] a);
		return {~a[7:0] ^ a[15:8], a[7:0] ^ a[19:12]};
	endfunction
	// Hold window and junk pattern
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_late_q <= 1'b0;
			junk_q <= 16'h0f0f;
		end else begin
			rd_late_q <= pm_rd;
			junk_q <= ~junk_q;
		end
	end
	assign pm_rdata = (pm_rd | rd_late_q) ? pm_word(pm_addr) : junk_q;
endmodule

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the executor.
// Assumes: APB answers with one wait state; program memory model attached.
// Notes: Expected values are worked out here.
`timescale 1ns/1ps
`include "rrte_cfg.svh"
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pm_rd;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [19:0] pm_addr;
	logic [15:0] pm_rdata;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;

	rrte_core i_rrte_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata));
	rrte_pm_model i_rrte_pm_model (.pclk(pclk), .presetn(presetn), .pm_addr(pm_addr),
		.pm_rd(pm_rd), .pm_rdata(pm_rdata));

	// ========
	// Clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			test_done;
		end
	end

	// ========
	// Shared tasks
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp, what);
	endtask
	task exec(input logic [31:0] op);
		logic [31:0] r;
		logic e;
		wr(`RRTE_OFS_INSTR, op);
		do apb(1'b0, `RRTE_OFS_STAT, 32'h0, r, e); while (r[0] !== 1'b0);
	endtask
	function automatic logic [15:0] pm_word(input logic [19:0] a);
		return {~a[7:0] ^ a[15:8], a[7:0] ^ a[19:12]};
	endfunction

	// ========
	// Scenarios
	task t_regs;
		logic [31:0] r;
		logic e;
		rd(`RRTE_OFS_BYTE_PTR, 32'h0, "pointer reset");
		wr(`RRTE_OFS_PC, 32'h1234);
		rd(`RRTE_OFS_PC, 32'h0, "pc read only");
		apb(1'b1, 12'h030, 32'h5, r, e);
		chk({31'h0, e}, 32'h1, "unmapped write");
		apb(1'b0, 12'h002, 32'h0, r, e);
		chk({r[31:1], e}, 32'h1, "misaligned read");
		apb(1'b0, 12'h082, 32'h0, r, e);
		chk({r[31:1], e}, 32'h1, "misaligned file read");
	endtask
	task t_rotate;
		wr(`RRTE_OFS_FLAGS, 32'h0);
		wr(`RRTE_OFS_FILE + 12'h00c, 32'he6);
		wr(`RRTE_OFS_BANK, 32'h1);
		wr(`RRTE_OFS_FILE + 12'h04c, 32'h80);
		exec(32'h3403);
		rd(`RRTE_OFS_WREG, 32'hcc, "rotate to w");
		rd(`RRTE_OFS_FLAGS, 32'h11, "rotate flags");
		rd(`RRTE_OFS_FILE + 12'h00c, 32'he6, "file kept");
		wr(`RRTE_OFS_FLAGS, 32'h0);
		exec(32'h3703);
		rd(`RRTE_OFS_FILE + 12'h04c, 32'h0, "banked rotate");
		rd(`RRTE_OFS_FLAGS, 32'h05, "zero flags");
		rd(`RRTE_OFS_WREG, 32'hcc, "w kept");
		exec(32'h3603);
		rd(`RRTE_OFS_FILE + 12'h00c, 32'hcd, "access bank");
	endtask
	task t_skip;
		wr(`RRTE_OFS_FILE + 12'h014, 32'h08);
		exec(32'h0a605);
		rd(`RRTE_OFS_STAT, 32'h22, "skip taken");
		exec(32'h1a605);
		rd(`RRTE_OFS_STAT, 32'h32, "skip two words");
		exec(32'h1a405);
		rd(`RRTE_OFS_STAT, 32'h10, "no skip");
	endtask
	task t_return;
		wr(`RRTE_OFS_STACK_TOP, 32'h1abcde);
		wr(`RRTE_OFS_SHADOW, 32'h011577);
		wr(`RRTE_OFS_LATCH, 32'hbeef);
		wr(`RRTE_OFS_WREG, 32'h11);
		exec(32'h13);
		rd(`RRTE_OFS_PC, 32'h1abcde, "pop");
		rd(`RRTE_OFS_WREG, 32'h77, "w restore");
		rd(`RRTE_OFS_FLAGS, 32'h15, "flags restore");
		rd(`RRTE_OFS_BANK, 32'h01, "bank restore");
		rd(`RRTE_OFS_LATCH, 32'hbeef, "latches kept");
		rd(`RRTE_OFS_STAT, 32'h20, "return cycles");
		wr(`RRTE_OFS_STACK_TOP, 32'h123);
		wr(`RRTE_OFS_WREG, 32'h22);
		exec(32'h12);
		rd(`RRTE_OFS_PC, 32'h123, "plain pop");
		rd(`RRTE_OFS_WREG, 32'h22, "no restore");
		rd(`RRTE_OFS_FLAGS, 32'h15, "return flags");
		// Unrecognised opcode runs as a one-cycle no_operation
		exec(32'h0);
		rd(`RRTE_OFS_STAT, 32'h10, "no_operation cycles");
		rd(`RRTE_OFS_WREG, 32'h22, "no_operation keeps w");
		rd(`RRTE_OFS_FLAGS, 32'h15, "no_operation keeps flags");
	endtask
	task t_table;
		logic [20:0] p, q, a;
		logic [15:0] w;
		logic [20:0] starts [4];
		starts = '{21'h00a356, 21'h1fffff, 21'h000000, 21'h01a357};
		for (int m = 0; m < 4; m++) begin
			p = starts[m];
			q = (m == 1 || m == 3) ? p + 21'h1 : ((m == 2) ? p - 21'h1 : p);
			a = (m == 3) ? q : p;
			w = pm_word(a[20:1]);
			wr(`RRTE_OFS_BYTE_PTR, {11'h0, p});
			exec(32'h8 + 32'(m));
			rd(`RRTE_OFS_TBLLAT, {24'h0, a[0] ? w[15:8] : w[7:0]}, "latch");
			rd(`RRTE_OFS_BYTE_PTR, {11'h0, q}, "pointer");
			rd(`RRTE_OFS_STAT, 32'h20, "table cycles");
		end
		rd(`RRTE_OFS_FLAGS, 32'h15, "table flags");
	endtask

	// ========
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_rotate;
		t_skip;
		t_return;
		t_table;
		test_done;
	end
endmodule
